// ===== logic/stq_core.sv
module stq_core
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic controlWrite,
   input stq_pkg::stq_ctrl_s controlIn,
   input wire logic statusControlWrite,
   input stq_pkg::stq_scfg_s statusControlIn,
   input wire logic statusRead,
   input wire logic dataRead,
   input wire logic txWrite,
   input wire logic [stq_pkg::BYTE_W-1:0] txData,
   output logic txReady,
   output stq_pkg::stq_status_s status,
   output logic [stq_pkg::BYTE_W-1:0] rxData,
   output logic errorIrq,
   input wire logic sclkIn,
   input wire logic mosiIn,
   input wire logic misoIn,
   input wire logic selectIn_n,
   output stq_pkg::stq_pins_s pins
);
   import stq_pkg::*;

   stq_core_s q;
   stq_core_s d;
   logic fifoValid;
   logic [BYTE_W-1:0] fifoData;
   logic [CNT_W-1:0] fifoCount;
   logic fifoPop;
   logic fifoFlush;
   logic ss;
   logic sclkS;
   logic serIn;
   logic isMaster;
   logic tick;
   logic lead;
   logic trail;
   logic sampleEv;
   logic driveEv;
   logic endEv;
   logic faultCond;
   logic [3:0] cntNext;
   logic [BYTE_W-1:0] word;

   function automatic logic [BYTE_W-1:0] pickWord(input logic valid,
                                                  input logic [BYTE_W-1:0] queued,
                                                  input logic [BYTE_W-1:0] held);
      return valid ? queued : held;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // transmit queue; its ready is the port software must respect

   stq_two_buffer txQueue
   (
      .clk(clk),
      .reset_n(reset_n),
      .flush(fifoFlush),
      .inValid(txWrite),
      .inData(txData),
      .inReady(txReady),
      .outValid(fifoValid),
      .outData(fifoData),
      .outReady(fifoPop),
      .count(fifoCount)
   );

   ////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      d = q;
      fifoPop = 1'b0;
      fifoFlush = 1'b0;
      word = q.rxShift;
      // pins pass two flops; only the second stage is looked at
      d.sync1 = {selectIn_n, misoIn, mosiIn, sclkIn};
      d.sync2 = q.sync1;
      ss = q.sync2[SYNC_SS];
      sclkS = q.sync2[SYNC_SCLK];
      d.sclkPrev = sclkS;
      d.ssPrev = ss;
      isMaster = q.ctrl.masterSelect;
      serIn = isMaster ? q.sync2[SYNC_MISO] : q.sync2[SYNC_MOSI];
      faultCond = isMaster && q.cfg.faultDetectEnable && !ss;

      // software side; clears go first so a set later in this cycle wins
      if (controlWrite)
      begin
         d.ctrl = controlIn;
         if (q.faultArm && !faultCond)
         begin
            d.modeFault = 1'b0;
         end
         d.faultArm = 1'b0;
      end
      if (statusControlWrite)
      begin
         d.cfg = statusControlIn;
      end
      if (statusRead)
      begin
         d.rxArm = q.rxFull;
         d.ovrArm = q.overrun;
         d.faultArm = q.modeFault;
      end
      if (dataRead)
      begin
         if (q.rxArm)
         begin
            d.rxFull = 1'b0;
         end
         if (q.ovrArm)
         begin
            d.overrun = 1'b0;
         end
         d.rxArm = 1'b0;
         d.ovrArm = 1'b0;
      end
      if (txWrite && txReady)
      begin
         d.txEmpty = 1'b0;
      end

      // serial clock edges: generated in master, sampled in slave
      tick = 1'b0;
      if (isMaster)
      begin
         tick = (q.state == ST_BUSY) && (q.divCnt == DIV_W'(SCLK_HALF_CYC - 1));
         d.divCnt = tick ? '0 : q.divCnt + 1'b1;
         lead = tick && (q.sclkGen == q.ctrl.clockPolarity);
         trail = tick && (q.sclkGen != q.ctrl.clockPolarity);
         if (tick)
         begin
            d.sclkGen = !q.sclkGen;
         end
      end
      else
      begin
         // a deselected slave sees no edges at all
         lead = !ss && (sclkS != q.sclkPrev) && (sclkS != q.ctrl.clockPolarity);
         trail = !ss && (sclkS != q.sclkPrev) && (sclkS == q.ctrl.clockPolarity);
      end
      sampleEv = (q.state == ST_BUSY) && (q.ctrl.clockPhase ? trail : lead);
      driveEv = (q.state == ST_BUSY) && (q.ctrl.clockPhase ? lead : trail);
      cntNext = q.sampleCnt + {3'h0, sampleEv};
      endEv = (q.state == ST_BUSY) && trail && (cntNext == BITS_PER_WORD);

      unique case (q.state)
         ST_IDLE:
         begin
            d.divCnt = '0;
            d.sclkGen = q.ctrl.clockPolarity;
            d.sampleCnt = '0;
            if (isMaster && fifoValid)
            begin
               d.state = ST_BUSY;
               d.txShift = fifoData;
               fifoPop = 1'b1;
               d.pins.mosiOut = fifoData[BYTE_W-1];
            end
            else if (!isMaster && !q.ctrl.clockPhase && q.ssPrev && !ss)
            begin
               d.state = ST_BUSY;
               d.txShift = pickWord(fifoValid, fifoData, q.txShift);
               fifoPop = fifoValid;
               d.pins.misoOut = d.txShift[BYTE_W-1];
            end
            else if (!isMaster && q.ctrl.clockPhase && lead)
            begin
               d.state = ST_BUSY;
               d.txShift = pickWord(fifoValid, fifoData, q.txShift);
               fifoPop = fifoValid;
               d.pins.misoOut = d.txShift[BYTE_W-1];
            end
         end
         ST_BUSY:
         begin
            // the queue is not touched until the word is over
            if (sampleEv)
            begin
               d.rxShift = {q.rxShift[BYTE_W-2:0], serIn};
               d.sampleCnt = cntNext;
               if (q.sampleCnt == OVR_SAMPLE_IDX && q.rxFull)
               begin
                  d.overrun = 1'b1;
               end
            end
            if (driveEv && q.sampleCnt < BITS_PER_WORD)
            begin
               d.pins.mosiOut = q.txShift[~q.sampleCnt[2:0]];
               d.pins.misoOut = q.txShift[~q.sampleCnt[2:0]];
            end
            if (endEv)
            begin
               word = d.rxShift;
               if (!d.overrun)
               begin
                  d.rxData = word;
                  d.rxFull = 1'b1;
               end
               d.txShift = word;
               d.sampleCnt = '0;
               d.state = ST_IDLE;
               if (isMaster && fifoValid)
               begin
                  d.state = ST_BUSY;
                  d.txShift = fifoData;
                  fifoPop = 1'b1;
                  d.pins.mosiOut = fifoData[BYTE_W-1];
                  d.divCnt = '0;
               end
            end
            if (!isMaster && ss)
            begin
               // slave deselected mid-word; the transfer is dropped and, with fault detection on, mode fault is set
               if (q.cfg.faultDetectEnable)
               begin
                  d.modeFault = 1'b1;
               end
               d.state = ST_IDLE;
               d.sampleCnt = '0;
            end
         end
      endcase

      // tx-empty sets once the last queued byte has left for the shifter
      if (fifoPop && fifoCount == CNT_W'(1) && !(txWrite && txReady))
      begin
         d.txEmpty = 1'b1;
      end

      if (faultCond)
      begin
         d.modeFault = 1'b1;
         d.ctrl.moduleEnable = 1'b0;
      end

      // disabled or master-faulted: abort, drop the queue, release the pins
      if (!d.ctrl.moduleEnable)
      begin
         d.state = ST_IDLE;
         d.sampleCnt = '0;
         d.txEmpty = 1'b1;
         fifoFlush = 1'b1;
         d.sclkGen = d.ctrl.clockPolarity;
      end
      d.pins.sclkOut = d.sclkGen;
      d.pins.sclkOe = d.ctrl.moduleEnable && d.ctrl.masterSelect;
      d.pins.mosiOe = d.ctrl.moduleEnable && d.ctrl.masterSelect;
      d.pins.misoOe = d.ctrl.moduleEnable && !d.ctrl.masterSelect && !ss;
      d.errorIrq = q.cfg.errorIrqEnable && (q.overrun || q.modeFault);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= CORE_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   assign status = '{txEmptyFlag: q.txEmpty, rxFullFlag: q.rxFull, overrunFlag: q.overrun,
                     modeFaultFlag: q.modeFault, masterSelect: q.ctrl.masterSelect,
                     moduleEnable: q.ctrl.moduleEnable};
   assign rxData = q.rxData;
   assign errorIrq = q.errorIrq;
   assign pins = q.pins;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   tx_empty_clear_a: assert property (
      txWrite && txReady && d.ctrl.moduleEnable |=> !status.txEmptyFlag)
      else $error("tx-empty still set after an accepted write");

   tx_empty_refill_a: assert property (
      fifoPop && fifoCount == CNT_W'(1) && !txWrite |-> ##[1:2] status.txEmptyFlag)
      else $error("tx-empty not set within two cycles of unloading");

   overrun_set_a: assert property (
      sampleEv && q.sampleCnt == OVR_SAMPLE_IDX && q.rxFull |=> status.overrunFlag)
      else $error("overrun missed at bit 1 capture");

   rx_data_hold_a: assert property (
      status.overrunFlag && !dataRead |=> $stable(rxData) && $stable(status.rxFullFlag))
      else $error("receive data changed during overrun");

   master_fault_a: assert property (
      faultCond |=> status.modeFaultFlag && !status.moduleEnable && status.txEmptyFlag
                    && !pins.sclkOe && q.state == ST_IDLE)
      else $error("master fault effects missing");

   fault_gate_a: assert property (
      !q.cfg.faultDetectEnable && !status.modeFaultFlag |=> !status.modeFaultFlag)
      else $error("mode fault set while detection disabled");

   error_irq_a: assert property (
      q.cfg.errorIrqEnable && (status.overrunFlag || status.modeFaultFlag) |=> errorIrq)
      else $error("error interrupt not raised");

   miso_release_a: assert property (
      !isMaster && ss |=> !pins.misoOe)
      else $error("miso driven while deselected");

   back_to_back_a: assert property (
      endEv && isMaster && fifoValid && d.ctrl.moduleEnable |=> q.state == ST_BUSY)
      else $error("master idled with a queued byte");

   select_kept_a: assert property (
      !status.modeFaultFlag && !controlWrite ##1 status.modeFaultFlag
      |-> $stable(status.masterSelect))
      else $error("master select changed by a fault");

   master_word_c: cover property (endEv && isMaster);
   chained_word_c: cover property (endEv && isMaster && fifoValid);
   overrun_c: cover property ($rose(status.overrunFlag));
   slave_fault_c: cover property (!isMaster && $rose(status.modeFaultFlag));

endmodule

// ===== logic/stq_pkg.sv
package stq_pkg;

   localparam int BYTE_W = 8;
   localparam int BUF_DEPTH = 2;
   localparam int PTR_W = 1;
   localparam int CNT_W = 2;
   localparam int CLK_MHZ = 200;
   // master serial clock period; half of it is one serial clock phase
   localparam int SCLK_PERIOD_NS = 80;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS * CLK_MHZ / 2000;
   localparam int DIV_W = 4;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   // bit 1 is captured by the seventh sample, when six are already in
   localparam logic [3:0] OVR_SAMPLE_IDX = 4'h6;
   localparam int SYNC_SCLK = 0;
   localparam int SYNC_MOSI = 1;
   localparam int SYNC_MISO = 2;
   localparam int SYNC_SS = 3;

   typedef enum logic {ST_IDLE, ST_BUSY} stq_phase_e;

   typedef struct packed {
      logic moduleEnable;
      logic masterSelect;
      logic clockPhase;
      logic clockPolarity;
   } stq_ctrl_s;

   typedef struct packed {
      logic faultDetectEnable;
      logic errorIrqEnable;
   } stq_scfg_s;

   typedef struct packed {
      logic txEmptyFlag;
      logic rxFullFlag;
      logic overrunFlag;
      logic modeFaultFlag;
      logic masterSelect;
      logic moduleEnable;
   } stq_status_s;

   typedef struct packed {
      logic sclkOut;
      logic sclkOe;
      logic mosiOut;
      logic mosiOe;
      logic misoOut;
      logic misoOe;
   } stq_pins_s;

   typedef struct packed {
      logic [BUF_DEPTH-1:0][BYTE_W-1:0] mem;
      logic [PTR_W-1:0] wrPtr;
      logic [PTR_W-1:0] rdPtr;
      logic [CNT_W-1:0] count;
   } stq_buf_s;

   typedef struct packed {
      stq_phase_e state;
      stq_ctrl_s ctrl;
      stq_scfg_s cfg;
      logic txEmpty;
      logic rxFull;
      logic overrun;
      logic modeFault;
      logic rxArm;
      logic ovrArm;
      logic faultArm;
      logic [BYTE_W-1:0] rxData;
      logic [BYTE_W-1:0] txShift;
      logic [BYTE_W-1:0] rxShift;
      logic [3:0] sampleCnt;
      logic [DIV_W-1:0] divCnt;
      logic sclkGen;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic sclkPrev;
      logic ssPrev;
      stq_pins_s pins;
      logic errorIrq;
   } stq_core_s;

   localparam stq_buf_s BUF_RESET = '{default: '0};
   // select synchronisers start at the pin's idle level, so release shows no false select
   localparam stq_core_s CORE_RESET = '{state: ST_IDLE, txEmpty: 1'b1, sync1: 4'h8, sync2: 4'h8,
                                        ssPrev: 1'b1, default: '0};

endpackage

// ===== logic/stq_two_buffer.sv
module stq_two_buffer
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic inValid,
   input wire logic [stq_pkg::BYTE_W-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [stq_pkg::BYTE_W-1:0] outData,
   input wire logic outReady,
   output logic [stq_pkg::CNT_W-1:0] count
);
   import stq_pkg::*;

   stq_buf_s q;
   stq_buf_s d;
   logic push;
   logic pop;

   assign inReady = (q.count != CNT_W'(BUF_DEPTH));
   assign outValid = (q.count != '0);
   assign outData = q.mem[q.rdPtr];
   assign count = q.count;

   always_comb
   begin
      d = q;
      push = inValid && inReady;
      pop = outValid && outReady;
      if (push)
      begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr = q.wrPtr + 1'b1;
      end
      if (pop)
      begin
         d.rdPtr = q.rdPtr + 1'b1;
      end
      d.count = q.count + CNT_W'(push) - CNT_W'(pop);
      // a flush drops whatever is queued, a write in the same cycle too
      if (flush)
      begin
         d.wrPtr = '0;
         d.rdPtr = '0;
         d.count = '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= BUF_RESET;
      end
      else
      begin
         q <= d;
      end
   end

endmodule

// ===== sim/stq_spi_partner.sv
// far-side serial slave for master-mode runs: clock phase 0, polarity 0, msb first
module stq_spi_partner
(
   input wire logic sclk,
   input wire logic active,
   input wire logic mosi,
   input wire logic [7:0] txByte,
   output logic miso,
   output logic [3:0][7:0] rxHist,
   output int words
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh;
   logic [7:0] rx;
   int bitCnt;
   initial
   begin
      sh = 8'h00;
      rx = 8'h00;
      rxHist = '0;
      words = 0;
      bitCnt = 0;
   end
   ////////////////////////////////////////////////////////////
   // a released line shows the inverse, so a stale bit never passes as data
   assign miso = active ? sh[7] : ~sh[7];
   always @(posedge sclk)
   begin
      rx <= {rx[6:0], mosi};
   end
   // txByte is only changed while the link is inactive; each word sends txByte plus its index
   always @(negedge sclk or negedge active or txByte)
   begin
      if (!active)
      begin
         sh <= txByte + 8'(words);
         bitCnt <= 0;
      end
      else if (bitCnt == 7)
      begin
         rxHist[words % 4] <= rx;
         words <= words + 1;
         sh <= txByte + 8'(words + 1);
         bitCnt <= 0;
      end
      else
      begin
         sh <= {sh[6:0], 1'b0};
         bitCnt <= bitCnt + 1;
      end
   end
endmodule

// ===== sim/test_stq_core.sv
module test_stq_core;
   timeunit 1ns;
   timeprecision 100ps;
   import stq_pkg::*;
   logic clk = 1'b0;
   logic reset_n, controlWrite, statusControlWrite, statusRead, dataRead, txWrite;
   logic sclkIn, mosiIn, selectIn_n, misoWire, txReady, errorIrq;
   logic [7:0] txData, rxData, partnerTx, a, b, p, g;
   logic [3:0][7:0] partnerRx;
   logic [31:0] seed;
   stq_ctrl_s controlIn;
   stq_scfg_s statusControlIn;
   stq_status_s status;
   stq_pins_s pins;
   int partnerWords, err_count, check_count, cyc, i, t1;
   stq_core uut (.clk(clk), .reset_n(reset_n), .controlWrite(controlWrite),
      .controlIn(controlIn), .statusControlWrite(statusControlWrite),
      .statusControlIn(statusControlIn), .statusRead(statusRead), .dataRead(dataRead),
      .txWrite(txWrite), .txData(txData), .txReady(txReady), .status(status),
      .rxData(rxData), .errorIrq(errorIrq), .sclkIn(sclkIn), .mosiIn(mosiIn),
      .misoIn(misoWire), .selectIn_n(selectIn_n), .pins(pins));
   stq_spi_partner partner (.sclk(pins.sclkOut), .active(pins.sclkOe), .mosi(pins.mosiOut),
      .txByte(partnerTx), .miso(misoWire), .rxHist(partnerRx), .words(partnerWords));
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chkBit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic setCtrl(input logic en, input logic ms, input logic ph);
      controlIn = {en, ms, ph, 1'b0};
      pulse(controlWrite);
   endtask
   task automatic setCfg(input logic fde, input logic eie);
      statusControlIn = {fde, eie};
      pulse(statusControlWrite);
   endtask
   task automatic writeTx(input logic [7:0] v);
      for (int k = 0; k < 400 && status.txEmptyFlag !== 1'b1; k++) tick(1);
      txData = v;
      pulse(txWrite);
   endtask
   // link clock is stepped in 40 ns halves, kept off the system clock edges;
   // phase 0 reads miso at the leading edge, phase 1 just before the trailing one
   task automatic frame(input logic ph, input logic [7:0] v, output logic [7:0] got);
      #1.3;
      selectIn_n = 1'b0;
      mosiIn = v[7];
      #40;
      for (int k = 7; k >= 0; k--)
      begin
         sclkIn = 1'b1;
         if (ph)
            mosiIn = v[k];
         else
            got[k] = pins.misoOut;
         #40;
         if (ph)
            got[k] = pins.misoOut;
         sclkIn = 1'b0;
         if (!ph)
            mosiIn = (k > 0) ? v[(k + 7) % 8] : ~v[0];
         #40;
      end
      selectIn_n = 1'b1;
      tick(8);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      {reset_n, controlWrite, statusControlWrite, statusRead, dataRead, txWrite} = '0;
      {sclkIn, mosiIn, controlIn, statusControlIn, txData} = '0;
      selectIn_n = 1'b1;
      seed = 32'h128c;
      {err_count, check_count, cyc, t1} = '0;
      a = rnd();
      b = rnd();
      p = rnd();
      partnerTx = p;
      tick(6);
      reset_n = 1'b1;
      tick(1);
      chkVal("status", 16'h20, 16'(status));
      chkVal("pins", 16'h0, 16'(pins));
      chkBit("txReady", 1'b1, txReady);
      // master: two queued words while the far side keeps talking
      setCfg(1'b1, 1'b1);
      setCtrl(1'b1, 1'b1, 1'b0);
      tick(2);
      chkVal("pins oe", 16'h14, 16'(pins) & 16'h15);
      writeTx(a);
      chkBit("txEmpty", 1'b0, status.txEmptyFlag);
      tick(2);
      chkBit("txEmpty", 1'b1, status.txEmptyFlag);
      writeTx(b);
      tick(1);
      chkBit("txEmpty", 1'b0, status.txEmptyFlag);
      for (i = 0; i < 600 && partnerWords < 2; i++)
      begin
         tick(1);
         if (partnerWords == 1 && t1 == 0)
            t1 = i;
      end
      chkVal("gap", 16'h80, 16'(i - 1 - t1));
      chkVal("word0", {8'h0, a}, {8'h0, partnerRx[0]});
      chkVal("word1", {8'h0, b}, {8'h0, partnerRx[1]});
      tick(4);
      chkVal("rxData", {8'h0, p}, {8'h0, rxData});
      chkBit("overrun", 1'b1, status.overrunFlag);
      chkBit("rxFull", 1'b1, status.rxFullFlag);
      chkBit("errorIrq", 1'b1, errorIrq);
      pulse(statusRead);
      pulse(dataRead);
      pulse(statusRead);
      tick(2);
      chkBit("overrun", 1'b0, status.overrunFlag);
      chkBit("rxFull", 1'b0, status.rxFullFlag);
      chkBit("errorIrq", 1'b0, errorIrq);
      // master mode fault
      setCfg(1'b0, 1'b1);
      selectIn_n = 1'b0;
      tick(6);
      chkBit("modeFault", 1'b0, status.modeFaultFlag);
      setCfg(1'b1, 1'b1);
      tick(6);
      chkVal("fault status", 16'h26, 16'(status) & 16'h3f);
      chkVal("fault oe", 16'h0, 16'(pins) & 16'h15);
      chkBit("errorIrq", 1'b1, errorIrq);
      setCfg(1'b0, 1'b1);
      tick(1);
      chkBit("modeFault", 1'b1, status.modeFaultFlag);
      setCfg(1'b1, 1'b1);
      pulse(statusRead);
      setCtrl(1'b0, 1'b1, 1'b0);
      tick(1);
      chkBit("modeFault", 1'b1, status.modeFaultFlag);
      selectIn_n = 1'b1;
      tick(6);
      pulse(statusRead);
      setCtrl(1'b0, 1'b0, 1'b0);
      tick(1);
      chkBit("modeFault", 1'b0, status.modeFaultFlag);
      // slave frames driven from the far side
      setCtrl(1'b1, 1'b0, 1'b0);
      a = rnd();
      b = rnd();
      writeTx(a);
      tick(4);
      frame(1'b0, b, g);
      chkVal("miso word", {8'h0, a}, {8'h0, g});
      chkBit("misoOe", 1'b0, pins.misoOe);
      chkVal("rxData", {8'h0, b}, {8'h0, rxData});
      chkBit("modeFault", 1'b0, status.modeFaultFlag);
      pulse(statusRead);
      pulse(dataRead);
      frame(1'b0, rnd(), g);
      chkVal("miso repeat", {8'h0, b}, {8'h0, g});
      selectIn_n = 1'b0;
      tick(6);
      chkBit("misoOe", 1'b1, pins.misoOe);
      selectIn_n = 1'b1;
      tick(6);
      chkBit("modeFault", 1'b1, status.modeFaultFlag);
      chkBit("enable", 1'b1, status.moduleEnable);
      pulse(statusRead);
      setCtrl(1'b0, 1'b0, 1'b1);
      tick(1);
      setCtrl(1'b1, 1'b0, 1'b1);
      selectIn_n = 1'b0;
      tick(6);
      selectIn_n = 1'b1;
      tick(6);
      chkBit("modeFault", 1'b0, status.modeFaultFlag);
      // phase 1 slave word: starts on the first clock edge with select already low
      pulse(statusRead);
      pulse(dataRead);
      a = rnd();
      b = rnd();
      writeTx(a);
      tick(4);
      frame(1'b1, b, g);
      chkVal("miso word ph1", {8'h0, a}, {8'h0, g});
      chkVal("rxData ph1", {8'h0, b}, {8'h0, rxData});
      chkBit("modeFault", 1'b0, status.modeFaultFlag);
      // busy slave holds its queue: fill until refused
      setCtrl(1'b1, 1'b0, 1'b0);
      selectIn_n = 1'b0;
      tick(6);
      txData = rnd();
      pulse(txWrite);
      tick(1);
      txData = rnd();
      pulse(txWrite);
      tick(1);
      chkBit("txReady", 1'b0, txReady);
      chkBit("txEmpty", 1'b0, status.txEmptyFlag);
      setCtrl(1'b0, 1'b0, 1'b0);
      selectIn_n = 1'b1;
      tick(4);
      chkBit("txReady", 1'b1, txReady);
      finish_test();
   end
endmodule
